// ==== hdl/rlc_pkg.sv ====
`default_nettype none

package rlc_pkg;

    // Bus geometry
    localparam int unsigned RLC_ADDR_W = 12;
    localparam int unsigned RLC_DATA_W = 32;

    // Register byte offsets
    localparam logic [RLC_ADDR_W-1:0] RLC_OFS_CONTROL = 12'h000;
    localparam logic [RLC_ADDR_W-1:0] RLC_OFS_STATUS = 12'h004;

    // Control register layout
    localparam int unsigned RLC_CTRL_W = 8;
    localparam int unsigned RLC_TAP_W = 5;
    localparam int unsigned RLC_TAP_COUNT = 32;
    localparam int unsigned RLC_BIT_POWER = 7;
    localparam int unsigned RLC_BIT_PIN = 6;
    localparam int unsigned RLC_BIT_SRC = 5;
    localparam logic [RLC_CTRL_W-1:0] RLC_CTRL_RESET = 8'h00;

    // Status register layout
    localparam int unsigned RLC_STAT_W = 8;
    localparam int unsigned RLC_STAT_LEVEL_LIVE = 0;
    localparam int unsigned RLC_STAT_PIN_LIVE = 1;
    localparam int unsigned RLC_STAT_PIN_IDLE = 2;
    localparam logic [RLC_STAT_W-1:0] RLC_STAT_RESET = 8'h00;

    // Field image of the control register, bit 7 first
    typedef struct packed {
        logic ladder_power_on;
        logic level_pin_drive;
        logic external_source_select;
        logic [RLC_TAP_W-1:0] tap_select_code;
    } rlc_ctrl_s;

    // Register selected by a bus address
    typedef enum logic [1:0] {
        RLC_SEL_CONTROL,
        RLC_SEL_STATUS,
        RLC_SEL_NONE
    } rlc_sel_e;

    // Address decode, shared by the read and write paths
    function automatic rlc_sel_e rlc_decode(input logic [RLC_ADDR_W-1:0] addr);
        rlc_sel_e sel;
        sel = RLC_SEL_NONE;
        if (addr == RLC_OFS_CONTROL) begin
            sel = RLC_SEL_CONTROL;
        end else if (addr == RLC_OFS_STATUS) begin
            sel = RLC_SEL_STATUS;
        end
        return sel;
    endfunction

endpackage

`default_nettype wire

// ==== hdl/rlc_apb_slave.sv ====
`default_nettype none

module rlc_apb_slave (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [rlc_pkg::RLC_ADDR_W-1:0] i_paddr,
    input wire logic [rlc_pkg::RLC_DATA_W-1:0] i_pwdata,
    output logic o_pready,
    output logic [rlc_pkg::RLC_DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    // Register side
    input wire logic [rlc_pkg::RLC_CTRL_W-1:0] i_ctrl_word,
    input wire logic [rlc_pkg::RLC_STAT_W-1:0] i_stat_word,
    output logic o_ctrl_wr,
    output logic [rlc_pkg::RLC_CTRL_W-1:0] o_ctrl_wdata
);
    import rlc_pkg::*;

    logic pready_q;
    logic pready_d;
    logic [RLC_DATA_W-1:0] prdata_q;
    logic [RLC_DATA_W-1:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic setup;
    rlc_sel_e sel;

    assign setup = i_psel && !i_penable && !pready_q;
    assign sel = rlc_decode(i_paddr);

    // One wait-free access phase: ready is raised in the cycle after setup
    assign pready_d = setup;
    assign pslverr_d = setup && (sel == RLC_SEL_NONE);

    always_comb begin
        prdata_d = '0;
        if (setup && !i_pwrite) begin
            case (sel)
                RLC_SEL_CONTROL: prdata_d = {{(RLC_DATA_W-RLC_CTRL_W){1'b0}}, i_ctrl_word};
                RLC_SEL_STATUS: prdata_d = {{(RLC_DATA_W-RLC_STAT_W){1'b0}}, i_stat_word};
                default: prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Write lands at the completing edge; status writes are dropped quietly
    assign o_ctrl_wr = i_psel && i_penable && pready_q && i_pwrite
        && (sel == RLC_SEL_CONTROL);
    assign o_ctrl_wdata = i_pwdata[RLC_CTRL_W-1:0];

    assign o_pready = pready_q;
    assign o_prdata = prdata_q;
    assign o_pslverr = pslverr_q;

endmodule

`default_nettype wire

// ==== hdl/rlc_tap_decoder.sv ====
`default_nettype none

module rlc_tap_decoder #(
    parameter int unsigned TAP_W = rlc_pkg::RLC_TAP_W,
    parameter int unsigned TAP_COUNT = rlc_pkg::RLC_TAP_COUNT
) (
    // Tap code in
    input wire logic [TAP_W-1:0] i_code,
    input wire logic i_enable,
    // One switch per ladder node
    output logic [TAP_COUNT-1:0] o_switch
);
    import rlc_pkg::*;

    // Exactly one node closes at a time; none while the ladder is off
    for (genvar n = 0; n < TAP_COUNT; n++) begin : g_tap
        assign o_switch[n] = i_enable && (i_code == TAP_W'(n));
    end

endmodule

`default_nettype wire

// ==== hdl/rlc_top.sv ====
// Functional notes
// - Power enable bit 7 powers the ladder; clear holds it powered down.
// - Output enable bit 6 closes the switch onto the level pin.
// - Bit 5 picks external reference rails (1) or analog supply rails (0).
// - Exactly 32 levels; one tap selected at a time by one code.
// - Tap code in bits 4:0, values 0 to 31, level is low rail plus code/32.
// - Reset clears the power enable, ladder off until software sets it.
// - Reset clears the output enable, pin disconnected.
// - Wake from sleep leaves the control register untouched.
// - Controls act independently of any comparator enable.
// - Reset returns the whole control register to its reset value.
`default_nettype none

module rlc_top (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [rlc_pkg::RLC_ADDR_W-1:0] i_paddr,
    input wire logic [rlc_pkg::RLC_DATA_W-1:0] i_pwdata,
    output logic o_pready,
    output logic [rlc_pkg::RLC_DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    // Ladder controls
    output logic o_ladder_power_on,
    output logic o_level_pin_drive,
    output logic o_external_source_select,
    output logic [rlc_pkg::RLC_TAP_W-1:0] o_tap_select_code,
    output logic [rlc_pkg::RLC_TAP_COUNT-1:0] o_tap_switch
);
    import rlc_pkg::*;

    rlc_ctrl_s ctrl_q;
    rlc_ctrl_s ctrl_d;
    logic [RLC_TAP_COUNT-1:0] switch_q;
    logic [RLC_TAP_COUNT-1:0] switch_d;
    logic [RLC_STAT_W-1:0] stat_q;
    logic [RLC_STAT_W-1:0] stat_d;
    logic ctrl_wr;
    logic [RLC_CTRL_W-1:0] ctrl_wdata;

    rlc_apb_slave u_bus (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .o_pready(o_pready),
        .o_prdata(o_prdata),
        .o_pslverr(o_pslverr),
        .i_ctrl_word(ctrl_q),
        .i_stat_word(stat_q),
        .o_ctrl_wr(ctrl_wr),
        .o_ctrl_wdata(ctrl_wdata)
    );

    // Only a control write or reset changes the register; there is no sleep or wake path,
    // so a wake-up can never disturb it
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = rlc_ctrl_s'(ctrl_wdata);
        end
    end

    // Switches decode from the next value so they change on the same edge
    rlc_tap_decoder #(
        .TAP_W(RLC_TAP_W),
        .TAP_COUNT(RLC_TAP_COUNT)
    ) u_taps (
        .i_code(ctrl_d.tap_select_code),
        .i_enable(ctrl_d.ladder_power_on),
        .o_switch(switch_d)
    );

    // Reset clears every bit, which powers down and disconnects the ladder
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= rlc_ctrl_s'(RLC_CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            switch_q <= '0;
        end else begin
            switch_q <= switch_d;
        end
    end

    // Status shows what the analog side is really given
    always_comb begin
        stat_d = RLC_STAT_RESET;
        stat_d[RLC_STAT_LEVEL_LIVE] = ctrl_d.ladder_power_on;
        stat_d[RLC_STAT_PIN_LIVE] = ctrl_d.ladder_power_on && ctrl_d.level_pin_drive;
        // Pin routed with the ladder off: the pin floats on a dead node
        stat_d[RLC_STAT_PIN_IDLE] = !ctrl_d.ladder_power_on && ctrl_d.level_pin_drive;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stat_q <= RLC_STAT_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Static controls straight from the register flops
    assign o_ladder_power_on = ctrl_q.ladder_power_on;
    assign o_level_pin_drive = ctrl_q.level_pin_drive;
    assign o_external_source_select = ctrl_q.external_source_select;
    assign o_tap_select_code = ctrl_q.tap_select_code;
    assign o_tap_switch = switch_q;

endmodule

`default_nettype wire

// ==== bench/rlc_properties.sv ====
`default_nettype none
module rlc_properties (
    // Clock, reset and bus
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [rlc_pkg::RLC_ADDR_W-1:0] i_paddr,
    input wire logic [rlc_pkg::RLC_DATA_W-1:0] i_pwdata,
    input wire logic o_pready,
    input wire logic [rlc_pkg::RLC_DATA_W-1:0] o_prdata,
    input wire logic o_pslverr,
    // Ladder controls
    input wire logic o_ladder_power_on,
    input wire logic o_level_pin_drive,
    input wire logic o_external_source_select,
    input wire logic [rlc_pkg::RLC_TAP_W-1:0] o_tap_select_code,
    input wire logic [rlc_pkg::RLC_TAP_COUNT-1:0] o_tap_switch
);
    timeunit 1ns;
    timeprecision 1ps;
    import rlc_pkg::*;
    logic [7:0] ctrl_w;
    logic acc_w;
    assign ctrl_w = {o_ladder_power_on, o_level_pin_drive, o_external_source_select,
        o_tap_select_code};
    assign acc_w = i_psel && i_penable && o_pready;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_ctrl_wr;
        i_psel && !i_penable && i_pwrite && i_paddr == RLC_OFS_CONTROL ##1 acc_w;
    endsequence
    AST_POWER: assert property (s_ctrl_wr |=> o_ladder_power_on == $past(i_pwdata[7]))
        else $error("power bit wrong");
    AST_PIN: assert property (s_ctrl_wr |=> o_level_pin_drive == $past(i_pwdata[6]))
        else $error("pin bit wrong");
    AST_SRC: assert property (s_ctrl_wr |=> o_external_source_select == $past(i_pwdata[5]))
        else $error("source bit wrong");
    AST_TAP: assert property (s_ctrl_wr |=> o_tap_select_code == $past(i_pwdata[4:0]))
        else $error("tap code wrong");
    // Only a control write may move the ladder, never a read or a refused access
    AST_HOLD: assert property (!(acc_w && i_pwrite && i_paddr == RLC_OFS_CONTROL)
        |=> $stable(ctrl_w)) else $error("controls moved");
    AST_READY: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready");
    AST_READ: assert property (acc_w && !i_pwrite && i_paddr == RLC_OFS_CONTROL
        |-> o_prdata == {24'h0, ctrl_w}) else $error("read data wrong");
    AST_ERR: assert property (acc_w && i_paddr != RLC_OFS_CONTROL
        && i_paddr != RLC_OFS_STATUS |-> o_pslverr && o_prdata == '0) else $error("no error");
    AST_SWITCH: assert property (o_tap_switch
        == (o_ladder_power_on ? 32'h1 << o_tap_select_code : 32'h0)) else $error("switch wrong");
    AST_RESET: assert property (!$past(i_reset_n) |-> ctrl_w == 8'h00)
        else $error("reset value wrong");
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rlc_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [RLC_ADDR_W-1:0] i_paddr = '0;
    logic [RLC_DATA_W-1:0] i_pwdata = '0;
    logic o_pready, o_pslverr, o_ladder_power_on, o_level_pin_drive, o_external_source_select;
    logic [RLC_DATA_W-1:0] o_prdata;
    logic [RLC_TAP_W-1:0] o_tap_select_code;
    logic [RLC_TAP_COUNT-1:0] o_tap_switch;
    logic [7:0] ctrl_o;
    logic [31:0] rd;
    logic er;
    int errors = 0;
    int checks_done = 0;
    assign ctrl_o = {o_ladder_power_on, o_level_pin_drive, o_external_source_select,
        o_tap_select_code};
    always #5 i_sys_clk = ~i_sys_clk;
    rlc_top DUT (.*);
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // Idle cycle after release, so no strobe is assigned twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            @(posedge i_sys_clk);
            if (o_pready === 1'b1) begin
                rd = o_prdata;
                er = o_pslverr;
                i_psel <= 1'b0;
                i_penable <= 1'b0;
                @(posedge i_sys_clk);
                return;
            end
        end
        errors++;
        close_out();
    endtask
    task automatic t_fields();
        logic [7:0] v;
        for (int i = 0; i < 64; i++) begin
            v = {i[5], i[0], i[1], i[4:0]};
            apb(1'b1, RLC_OFS_CONTROL, {24'hffffff, v});
            chk("write ok", 32'h0, {31'h0, er});
            chk("controls", {24'h0, v}, {24'h0, ctrl_o});
            chk("switches", v[7] ? 32'h1 << v[4:0] : 32'h0, o_tap_switch);
            apb(1'b0, RLC_OFS_CONTROL, 32'h0);
            chk("readback", {24'h0, v}, rd);
        end
        $display("fields test done");
    endtask
    task automatic t_refuse();
        apb(1'b1, RLC_OFS_CONTROL, 32'h4a);
        apb(1'b1, 12'h008, 32'hff);
        chk("write error", 32'h1, {31'h0, er});
        apb(1'b0, 12'hffc, 32'h0);
        chk("read error", 32'h1, {31'h0, er});
        chk("error data", 32'h0, rd);
        apb(1'b1, RLC_OFS_STATUS, 32'hff);
        chk("status write quiet", 32'h0, {31'h0, er});
        apb(1'b0, RLC_OFS_STATUS, 32'h0);
        chk("status", 32'h4, rd);
        chk("kept", 32'h4a, {24'h0, ctrl_o});
        chk("switches off", 32'h0, o_tap_switch);
        apb(1'b1, RLC_OFS_CONTROL, 32'hc0);
        chk("switches tap0", 32'h1, o_tap_switch);
        apb(1'b0, RLC_OFS_STATUS, 32'h0);
        chk("status live", 32'h3, rd);
        // Software powers the ladder down before sleep; the pin route stays
        apb(1'b1, RLC_OFS_CONTROL, 32'h40);
        chk("sleep prep", 32'h40, {24'h0, ctrl_o});
        chk("switches idle", 32'h0, o_tap_switch);
        $display("refusal test done");
    endtask
    task automatic t_reset();
        apb(1'b1, RLC_OFS_CONTROL, 32'hff);
        i_reset_n <= 1'b0;
        @(posedge i_sys_clk);
        chk("reset clears", 32'h0, {24'h0, ctrl_o});
        chk("reset switches", 32'h0, o_tap_switch);
        i_reset_n <= 1'b1;
        @(posedge i_sys_clk);
        apb(1'b0, RLC_OFS_CONTROL, 32'h0);
        chk("reset readback", 32'h0, rd);
        $display("reset test done");
    endtask
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(posedge i_sys_clk);
        chk("after reset", 32'h0, {24'h0, ctrl_o});
        t_fields();
        t_refuse();
        t_reset();
        close_out();
    end
endmodule
bind rlc_top rlc_properties PROPS (.*);
`default_nettype wire
